// File: rtl/blp_pkg.sv
// shared constants for the backlight brightness path
package blp_pkg;
    localparam int DUTY_W = 16;
    localparam int BRT_W = 8;
    localparam int CUR_W = 12;
    localparam int NUM_CH = 6;
    localparam int PWM_W = 12;
    localparam logic [BRT_W-1:0] BRT_RST = 8'hff;
    localparam logic [DUTY_W-1:0] DUTY_MAX = 16'hffff;
    localparam logic [DUTY_W-1:0] DUTY_ZERO = 16'h0000;
    localparam logic [CUR_W-1:0] CUR_ZERO = 12'h000;
    localparam logic [PWM_W-1:0] PWM_ZERO = 12'h000;
    localparam logic [PWM_W-1:0] PWM_ONE = 12'h001;
    localparam logic [3:0] RATE_ZERO = 4'h0;
    localparam int SHIFT_16_12 = 4;
    // source selection codes
    typedef enum logic [1:0] {
        BLP_SRC_PWM = 2'b00,
        BLP_SRC_MUL_PRE = 2'b01,
        BLP_SRC_REG = 2'b10,
        BLP_SRC_MUL_POST = 2'b11
    } blp_src_e;
    // dimming schemes
    typedef enum logic [1:0] {
        BLP_DIM_PWM = 2'b00,
        BLP_DIM_CUR = 2'b01,
        BLP_DIM_HYB = 2'b10
    } blp_dim_e;
    // curve shaper: squares the duty for a perceptual-like response
    function automatic logic [DUTY_W-1:0] blp_shape(input logic [DUTY_W-1:0] x);
        logic [2*DUTY_W-1:0] p;
        p = x * x;
        blp_shape = p[2*DUTY_W-1:DUTY_W];
    endfunction
    // duty times register, normalised so that 8'hff leaves duty unchanged
    function automatic logic [DUTY_W-1:0] blp_scale(input logic [DUTY_W-1:0] d,
                                                     input logic [BRT_W-1:0] b);
        logic [DUTY_W+BRT_W-1:0] p;
        p = d * b + {{BRT_W{1'b0}}, d};
        blp_scale = p[DUTY_W+BRT_W-1:BRT_W];
    endfunction
endpackage

// File: rtl/blp_duty_meter.sv
// input pwm duty measurement
`timescale 1ns/100ps
module blp_duty_meter
    import blp_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clocking
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // pwm input
    input wire logic pwm_in,
    // measured duty, full scale 16'hffff
    output logic [DUTY_W-1:0] duty
);
    logic prev_q, prev_d;
    logic [CNT_W-1:0] hi_q, hi_d, per_q, per_d;
    logic [DUTY_W-1:0] duty_q, duty_d;
    logic [CNT_W+DUTY_W-1:0] num;
    always_comb begin
        prev_d = pwm_in;
        hi_d = hi_q + CNT_W'(pwm_in);
        per_d = per_q + CNT_W'(1);
        duty_d = duty_q;
        num = {hi_q, {DUTY_W{1'b0}}} - {{DUTY_W{1'b0}}, hi_q};
        // rising edge closes a period
        if (pwm_in && !prev_q) begin
            hi_d = CNT_W'(1);
            per_d = CNT_W'(1);
            if (per_q != '0) begin
                duty_d = DUTY_W'(num / {{DUTY_W{1'b0}}, per_q});
            end
        end else if (&per_q) begin
            // stuck input: constant level means 0% or 100%
            per_d = per_q;
            hi_d = hi_q;
            duty_d = pwm_in ? DUTY_MAX : DUTY_ZERO;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_q <= 1'b0;
            hi_q <= '0;
            per_q <= '0;
            duty_q <= DUTY_ZERO;
        end else if (clk_en) begin
            prev_q <= prev_d;
            hi_q <= hi_d;
            per_q <= per_d;
            duty_q <= duty_d;
        end
    end
    assign duty = duty_q;
    property p_duty_full;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && (&per_q) && pwm_in && !(pwm_in && !prev_q)) |=> (duty_q == DUTY_MAX);
    endproperty
    a_duty_full: assert property (p_duty_full) else $error("stuck high not full");
endmodule

// File: rtl/blp_path.sv
// brightness path: source select, shaper, dimming, compensation, dither
`timescale 1ns/100ps
module blp_path
    import blp_pkg::*;
#(
    parameter int CH = NUM_CH
) (
    // clocking
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // host inputs
    input wire logic pwm_in,
    input wire logic brt_we,
    input wire logic [BRT_W-1:0] brt_wdata,
    // configuration
    input wire logic direct_passthrough,
    input wire logic [1:0] source_select,
    input wire logic [1:0] dim_scheme,
    input wire logic [BRT_W-1:0] hybrid_switch_point,
    input wire logic rate_from_resistor,
    input wire logic [3:0] freq_set_resistor,
    input wire logic [3:0] dimming_rate_select,
    input wire logic current_from_resistor,
    input wire logic [CUR_W-1:0] current_set_resistor,
    input wire logic [CUR_W-1:0] full_scale_fine,
    input wire logic [2:0] full_scale_range,
    // outputs
    output logic [BRT_W-1:0] brightness_level,
    output logic [CUR_W-1:0] led_current,
    output logic [CH-1:0] led_pwm
);
    logic [DUTY_W-1:0] duty;
    logic [BRT_W-1:0] brt_q, brt_d;
    logic [DUTY_W-1:0] shaped_q, shaped_d;
    logic [CUR_W-1:0] cur_q, cur_d, imax;
    logic [PWM_W-1:0] lvl_q, lvl_d, cnt_q, cnt_d;
    logic [3:0] div_q, div_d, rate;
    logic dith_q, dith_d;
    logic [CH-1:0] pwm_q, pwm_d;
    logic [DUTY_W-1:0] src, pre, post;
    logic [CUR_W-1:0] b12, cur_raw, th12;
    logic [CUR_W+CUR_W-1:0] cprod;
    logic [CUR_W-1:0] duty_lvl;

    // upper half of the full product; a plain sized cast would keep only the low half
    function automatic logic [CUR_W-1:0] mul_hi(input logic [CUR_W-1:0] a,
                                                 input logic [CUR_W-1:0] b);
        logic [CUR_W+CUR_W-1:0] p;
        p = a * b;
        mul_hi = p[CUR_W+CUR_W-1:CUR_W];
    endfunction

    blp_duty_meter #(.CNT_W(DUTY_W)) u_blp_duty_meter (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .pwm_in(pwm_in),
        .duty(duty)
    );

    // source combination and shaping
    always_comb begin
        brt_d = brt_we ? brt_wdata : brt_q;
        src = {brt_q, brt_q};
        case (blp_src_e'(source_select))
            BLP_SRC_PWM: pre = duty;
            BLP_SRC_MUL_PRE: pre = blp_scale(duty, brt_q);
            BLP_SRC_REG: pre = src;
            BLP_SRC_MUL_POST: pre = duty;
            default: pre = duty;
        endcase
        post = blp_shape(pre);
        if (blp_src_e'(source_select) == BLP_SRC_MUL_POST) begin
            post = blp_scale(post, brt_q);
        end
        shaped_d = post;
    end

    // maximum current selection
    always_comb begin
        cprod = current_set_resistor * full_scale_fine;
        if (current_from_resistor) begin
            imax = cprod[CUR_W+CUR_W-1:CUR_W] >> (3'h7 - full_scale_range);
        end else begin
            imax = full_scale_fine >> (3'h7 - full_scale_range);
        end
    end

    // dimming split between current and pwm
    always_comb begin
        b12 = shaped_q[DUTY_W-1:SHIFT_16_12];
        th12 = {hybrid_switch_point, 4'h0};
        cur_raw = imax;
        duty_lvl = b12;
        case (blp_dim_e'(dim_scheme))
            BLP_DIM_PWM: begin
                cur_raw = imax;
                duty_lvl = b12;
            end
            BLP_DIM_CUR: begin
                cur_raw = mul_hi(imax, b12);
                duty_lvl = {CUR_W{1'b1}};
            end
            BLP_DIM_HYB: begin
                // above the switch point current dims at full duty, below pwm dims
                if (b12 >= th12) begin
                    cur_raw = mul_hi(imax, b12);
                    duty_lvl = {CUR_W{1'b1}};
                end else begin
                    cur_raw = mul_hi(imax, th12);
                    duty_lvl = (th12 == CUR_ZERO) ? CUR_ZERO
                        : CUR_W'(({b12, 12'h000}) / {12'h000, th12});
                end
            end
            default: begin
                cur_raw = imax;
                duty_lvl = b12;
            end
        endcase
        // compensation: slight boost at low codes for sink non-linearity
        cur_d = (cur_raw == CUR_ZERO) ? CUR_ZERO
            : cur_raw + CUR_W'((~cur_raw) >> 6);
        lvl_d = duty_lvl;
    end

    // free-running output pwm, rate from resistor or field
    always_comb begin
        rate = rate_from_resistor ? freq_set_resistor : dimming_rate_select;
        div_d = div_q + 4'h1;
        cnt_d = cnt_q;
        dith_d = dith_q;
        if (div_q >= rate) begin
            div_d = RATE_ZERO;
            cnt_d = cnt_q + PWM_ONE;
            if (cnt_q == {PWM_W{1'b1}}) begin
                dith_d = ~dith_q;
            end
        end
        // dither: odd periods add one lsb to spread rounding error
        for (int i = 0; i < CH; i++) begin
            if (direct_passthrough) begin
                pwm_d[i] = pwm_in;
            end else begin
                pwm_d[i] = ({1'b0, cnt_q} < ({1'b0, lvl_q} + {12'h000, dith_q
                    && lvl_q != PWM_ZERO && lvl_q != {PWM_W{1'b1}}}));
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            brt_q <= BRT_RST;
            shaped_q <= DUTY_ZERO;
            cur_q <= CUR_ZERO;
            lvl_q <= PWM_ZERO;
            cnt_q <= PWM_ZERO;
            div_q <= RATE_ZERO;
            dith_q <= 1'b0;
            pwm_q <= '0;
        end else if (clk_en) begin
            brt_q <= brt_d;
            shaped_q <= shaped_d;
            cur_q <= cur_d;
            lvl_q <= lvl_d;
            cnt_q <= cnt_d;
            div_q <= div_d;
            dith_q <= dith_d;
            pwm_q <= pwm_d;
        end
    end

    assign brightness_level = brt_q;
    assign led_current = cur_q;
    assign led_pwm = pwm_q;

    property p_passthrough;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && direct_passthrough) |=> (led_pwm == {CH{$past(pwm_in)}});
    endproperty
    a_passthrough: assert property (p_passthrough) else $error("passthrough wrong");

    property p_reg_only;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && source_select == BLP_SRC_REG)
            |=> (shaped_q == blp_shape({$past(brt_q), $past(brt_q)}));
    endproperty
    a_reg_only: assert property (p_reg_only) else $error("register source wrong");

    property p_mode00;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && source_select == 2'b00) |=> (shaped_q == blp_shape($past(duty)));
    endproperty
    a_mode00: assert property (p_mode00) else $error("mode 00 wrong");

    property p_full_unity;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && source_select == BLP_SRC_MUL_PRE && brt_q == BRT_RST)
            |=> (shaped_q == blp_shape($past(duty)));
    endproperty
    a_full_unity: assert property (p_full_unity) else $error("full scale altered duty");

    property p_pwm_only_cur;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && dim_scheme == 2'b00 && imax != CUR_ZERO)
            |=> (led_current == $past(imax) + CUR_W'((~$past(imax)) >> 6));
    endproperty
    a_pwm_only_cur: assert property (p_pwm_only_cur) else $error("pwm-only current");

    property p_cur_full_duty;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && dim_scheme == 2'b01) |=> (lvl_q == {CUR_W{1'b1}});
    endproperty
    a_cur_full_duty: assert property (p_cur_full_duty) else $error("current mode duty");

    property p_rate;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && div_q >= rate) |=> (div_q == RATE_ZERO);
    endproperty
    a_rate: assert property (p_rate) else $error("rate divider wrong");

    property p_zero_off;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && !direct_passthrough && lvl_q == PWM_ZERO) |=> (led_pwm == '0);
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("zero duty not off");
endmodule

// File: sim/blp_host_pwm.sv
// host side model: free running external pwm source
`timescale 1ns/100ps
module blp_host_pwm (
    // clocking
    input wire logic clk,
    // waveform shape in clocks
    input wire logic [7:0] period,
    input wire logic [7:0] high_cnt,
    // pwm towards the device
    output logic pwm_in
);
    logic [7:0] cnt_q;
    initial begin
        cnt_q = 8'h00;
        pwm_in = 1'b0;
    end
    // updated on the edge so the device never sees a mid-cycle change
    always @(posedge clk) begin
        cnt_q <= (cnt_q + 8'h01 >= period) ? 8'h00 : cnt_q + 8'h01;
        pwm_in <= (cnt_q < high_cnt);
    end
endmodule

// File: sim/tb_blp_path.sv
// self-checking testbench for the brightness path
`timescale 1ns/100ps
module tb_blp_path;
    import blp_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, brt_we = 1'b0, direct_passthrough = 1'b0;
    logic rate_from_resistor = 1'b0, current_from_resistor = 1'b0, pwm_in, prev;
    logic [BRT_W-1:0] brt_wdata = 8'h00, brightness_level, period = 8'h40, high_cnt = 8'h30;
    logic [1:0] source_select = 2'b10, dim_scheme = 2'b00;
    logic [3:0] freq_set_resistor = 4'h0, dimming_rate_select = 4'h0;
    logic [2:0] full_scale_range = 3'h7;
    logic [BRT_W-1:0] switch_point = 8'h80;
    logic [CUR_W-1:0] iset_code = 12'hfff;
    logic [CUR_W-1:0] led_current, c0, c1, c2;
    logic [NUM_CH-1:0] led_pwm;
    int failures = 0, check_count = 0, cycles = 0, n0, n1, n2;
    always #2 clk = ~clk;
    blp_host_pwm u_blp_host_pwm (.clk(clk), .period(period), .high_cnt(high_cnt), .pwm_in(pwm_in));
    blp_path u_blp_path (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .pwm_in(pwm_in),
        .brt_we(brt_we), .brt_wdata(brt_wdata), .direct_passthrough(direct_passthrough),
        .source_select(source_select), .dim_scheme(dim_scheme),
        .hybrid_switch_point(switch_point),
        .rate_from_resistor(rate_from_resistor), .freq_set_resistor(freq_set_resistor),
        .dimming_rate_select(dimming_rate_select), .current_from_resistor(current_from_resistor),
        .current_set_resistor(iset_code), .full_scale_fine(12'hfff),
        .full_scale_range(full_scale_range), .brightness_level(brightness_level),
        .led_current(led_current), .led_pwm(led_pwm));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic write_brt(input logic [7:0] v);
        brt_we = 1'b1;
        brt_wdata = v;
        tick(1);
        brt_we = 1'b0;
        tick(1);
    endtask
    // long settle: duty meter needs several input periods
    task automatic cur_at(input logic [1:0] mode, input logic [7:0] v, output logic [11:0] c);
        source_select = mode;
        write_brt(v);
        tick(600);
        c = led_current;
    endtask
    // cycles from one rising output edge to the next; the first partial period is skipped
    task automatic period_of(output int n);
        int k;
        k = 0;
        n = 0;
        prev = led_pwm[0];
        while (k < 2) begin
            tick(1);
            if (k == 1) n++;
            if (led_pwm[0] === 1'b1 && prev === 1'b0) k++;
            prev = led_pwm[0];
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 95000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        tick(2);
        sys_rst = 1'b0;
        check(brightness_level, BRT_RST);
        check(led_current, CUR_ZERO);
        check(led_pwm, 6'h00);
        brt_we = 1'b1;
        brt_wdata = 8'h5a;
        tick(1);
        check(brightness_level, 8'h5a);
        brt_wdata = 8'ha5;
        tick(1);
        check(brightness_level, 8'ha5);
        // frozen while the enable is low
        clk_en = 1'b0;
        brt_wdata = 8'h00;
        tick(1);
        check(brightness_level, 8'ha5);
        brt_we = 1'b0;
        clk_en = 1'b1;
        $display("test register done");
        cur_at(2'b10, 8'h00, c0);
        cur_at(2'b10, 8'hff, c1);
        check(c0, c1);
        dim_scheme = 2'b01;
        cur_at(2'b10, 8'h00, c0);
        cur_at(2'b10, 8'hff, c1);
        check(c1 > c0, 1);
        full_scale_range = 3'h3;
        cur_at(2'b10, 8'hff, c2);
        check(c2 < c1, 1);
        full_scale_range = 3'h7;
        dim_scheme = 2'b10;
        cur_at(2'b10, 8'h20, c0);
        cur_at(2'b10, 8'h80, c1);
        check(c0, c1);
        cur_at(2'b10, 8'hff, c2);
        check(c2 > c1, 1);
        switch_point = 8'h00;
        cur_at(2'b10, 8'h80, c2);
        check(c2 < c1, 1);
        switch_point = 8'h80;
        dim_scheme = 2'b00;
        cur_at(2'b10, 8'hff, c0);
        current_from_resistor = 1'b1;
        iset_code = 12'h800;
        cur_at(2'b10, 8'hff, c1);
        check(c1 < c0, 1);
        current_from_resistor = 1'b0;
        dim_scheme = 2'b01;
        $display("test dimming done");
        cur_at(2'b00, 8'h00, c0);
        cur_at(2'b00, 8'hff, c1);
        check(c0, c1);
        cur_at(2'b01, 8'hff, c1);
        check(c1, c0);
        cur_at(2'b11, 8'hff, c1);
        check(c1, c0);
        cur_at(2'b01, 8'h40, c1);
        check(c1 < c0, 1);
        cur_at(2'b11, 8'h40, c1);
        check(c1 < c0, 1);
        high_cnt = 8'h10;
        cur_at(2'b00, 8'h40, c1);
        check(c1 < c0, 1);
        cur_at(2'b10, 8'h80, c1);
        high_cnt = 8'h30;
        cur_at(2'b10, 8'h80, c2);
        check(c1, c2);
        $display("test source done");
        dim_scheme = 2'b00;
        high_cnt = 8'h00;
        period_of(n0);
        check(n0, 16'(1 << PWM_W));
        dimming_rate_select = 4'h1;
        period_of(n1);
        check(n1, 16'(2 << PWM_W));
        rate_from_resistor = 1'b1;
        freq_set_resistor = 4'h2;
        period_of(n2);
        check(n2, 16'(3 << PWM_W));
        $display("test rate done");
        high_cnt = 8'h05;
        period = 8'h0b;
        direct_passthrough = 1'b1;
        for (int m = 0; m < 4; m++) begin
            source_select = m[1:0];
            tick(2);
            repeat (30) begin
                prev = pwm_in;
                tick(1);
                check(led_pwm, {NUM_CH{prev}});
            end
        end
        $display("test passthrough done");
        wrap_up();
    end
endmodule
